// [ccod_pkg.sv]
/*
  ccod_pkg: constants shared by the configuration-channel attach and
  orientation block: register offsets, field positions, reset values,
  termination codes and debounce cycle counts.
  assumes a 20 MHz system clock and a 32-bit AHB-Lite register bus.
*/
package ccod_pkg;
  // system clock
  localparam int CLK_PERIOD_NS = 50; // 20 MHz
  // debounce and toggle times, in their own unit
  localparam int PD_DEB_NS = 10000; // masks bmc toggling on cc
  localparam int CC_DEB_NS = 100000; // connection debounce
  localparam int DRP_HALF_NS = 50000; // time spent in each dual-role presentation
  // least times round up to whole cycles
  localparam logic [15:0] PD_DEB_CYC = 16'((PD_DEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] CC_DEB_CYC = 16'((CC_DEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] DRP_HALF_CYC = 16'((DRP_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_STAGE = 8'h08;
  // control field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_ROLE_LSB = 1;
  localparam int CTRL_VCONN_QUAL_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h1; // enabled, fixed source role
  // status field positions
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_CC1_LSB = 3;
  localparam int STAT_CC2_LSB = 5;
  localparam int STAT_SS_SEL_BIT = 7;
  localparam int STAT_CABLE_BIT = 8;
  localparam int STAT_CABLE_POS_BIT = 9;
  localparam int STAT_VBUS_BIT = 10;
  localparam int STAT_VCONN_LSB = 11;
  // port role selection
  localparam logic [1:0] ROLE_SRC = 2'h0;
  localparam logic [1:0] ROLE_SNK = 2'h1;
  localparam logic [1:0] ROLE_DUAL = 2'h2;
  // per-pin termination code seen as source
  typedef enum logic [1:0] {CC_OPEN, CC_SINK, CC_CABLE} ccod_term_t;
  // connection setup stages, strictly in order
  localparam logic [1:0] STAGE_DETECT = 2'h0;
  localparam logic [1:0] STAGE_ENUM = 2'h3;
  // attach state machine
  typedef enum logic [2:0] {
    ST_SRC_WAIT, ST_SRC_ATT, ST_SRC_DEBUG, ST_SRC_AUDIO, ST_SNK_WAIT, ST_SNK_ATT
  } ccod_state_t;
  // width of the debounced comparator vector
  localparam int FILT_W = 7;
endpackage

// [ccod_top.sv]
/*
  ccod_top: configuration-channel attach, orientation and role logic for one
  type-c port, with an AHB-Lite register slave.
  assumes the analogue front end gives per-pin comparator levels that are
  synchronous to hclk, and that the lane switch and power switches follow
  the enables it is given.
*/
// Implementation choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps

module ccod_top #(
  parameter int CNT_W = 16 // width of the debounce and toggle counters
) (
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // only word transfers are expected
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic [31:0] hrdata, // read data
  output logic hresp, // always okay
  input wire logic cc1_term, // cc1 below unterminated level
  input wire logic cc1_ra, // cc1 below cable-load level
  input wire logic cc2_term, // cc2 below unterminated level
  input wire logic cc2_ra, // cc2 below cable-load level
  input wire logic cc1_hi, // cc1 above local ground (sink role)
  input wire logic cc2_hi, // cc2 above local ground (sink role)
  input wire logic vbus_present, // vbus detected (sink role)
  output logic cc_pullup_en, // pull-ups on both cc pins
  output logic cc_pulldown_en, // pull-downs on both cc pins
  output logic vbus_en, // source vbus switch
  output logic vconn_cc1_en, // vconn onto cc1
  output logic vconn_cc2_en, // vconn onto cc2
  output logic ss_sel, // lane switch: 0 position 1, 1 position 2
  output logic debug_mode, // debug accessory configuration
  output logic audio_mode, // analog audio configuration
  output logic attached // valid source-to-sink connection
);
  import ccod_pkg::*;

  // bus and register state
  logic [3:0] ctrl_r; // enable, role, vconn qualifier
  logic [1:0] stage_r; // setup stage
  logic pend_r; // data phase pending
  logic pend_wr_r; // pending transfer is a write
  logic [7:0] pend_addr_r; // pending byte offset
  logic hreadyout_r; // wait-state generator
  logic [31:0] hrdata_r; // read data
  // attach state
  ccod_state_t st_r; // attach state
  ccod_state_t st_nxt; // its next value
  logic orient_r; // latched orientation, 1 for position 2
  logic present_src_r; // currently presenting pull-ups
  logic [CNT_W-1:0] tog_cnt_r; // dual-role toggle timer
  // filter chain: stage 0 pd debounce, stage 1 connection debounce
  logic [FILT_W-1:0] filt_in [2]; // input of each stage
  logic [FILT_W-1:0] filt_last_r [2]; // last sample
  logic [FILT_W-1:0] filt_out_r [2]; // accepted value
  logic [CNT_W-1:0] filt_cnt_r [2]; // stable count
  // output flops
  logic cc_pullup_en_r, cc_pulldown_en_r, vbus_en_r, vconn_cc1_en_r, vconn_cc2_en_r;
  logic ss_sel_r, debug_mode_r, audio_mode_r, attached_r;
  // classification of the debounced vector
  ccod_term_t cls1, cls2; // per-pin codes
  logic f_src, f_hi1, f_hi2; // debounced role and sink-side levels
  logic valid_src; // debounced data belongs to the current source presentation
  logic role_dual, en; // control fields

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // termination code per pin from the two comparator levels
  function automatic ccod_term_t term_code(input logic t, input logic ra);
    term_code = CC_OPEN;
    if (t) begin
      term_code = ra ? CC_CABLE : CC_SINK;
    end
  endfunction

  assign en = ctrl_r[CTRL_EN_BIT];
  assign role_dual = (ctrl_r[CTRL_ROLE_LSB +: 2] == ROLE_DUAL);
  // role bit rides in the vector so a role switch restarts debounce
  assign filt_in[0] = {present_src_r, cc1_term, cc1_ra, cc2_term, cc2_ra, cc1_hi, cc2_hi};
  assign filt_in[1] = filt_out_r[0];
  assign f_src = filt_out_r[1][6];
  assign cls1 = term_code(filt_out_r[1][5], filt_out_r[1][4]);
  assign cls2 = term_code(filt_out_r[1][3], filt_out_r[1][2]);
  assign f_hi1 = filt_out_r[1][1];
  assign f_hi2 = filt_out_r[1][0];
  assign valid_src = f_src && present_src_r;

  // two debounce stages; a short one hides pd signalling, a long one the contact
  for (genvar s = 0; s < 2; s++) begin : g_filt
    localparam logic [CNT_W-1:0] LIM = CNT_W'((s == 0) ? PD_DEB_CYC : CC_DEB_CYC);
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        filt_last_r[s] <= '0;
        filt_cnt_r[s] <= '0;
        filt_out_r[s] <= '0;
      // any raw change restarts both stages, not only the stage that sees it
      end else if (filt_in[s] != filt_last_r[s] || filt_in[0] != filt_last_r[0]) begin
        filt_last_r[s] <= filt_in[s];
        filt_cnt_r[s] <= '0;
      end else if (filt_cnt_r[s] < LIM) begin
        filt_cnt_r[s] <= filt_cnt_r[s] + 1'b1;
      end else begin
        filt_out_r[s] <= filt_last_r[s];
      end
    end
    a_filt_restart: assert property ((filt_in[s] != filt_last_r[s]) |=> filt_cnt_r[s] == '0)
      else $error("debounce not restarted on change");
  end

  // attach decisions from the debounced codes
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_SRC_WAIT: begin // powered cable alone stays here
        if (!valid_src) begin
          st_nxt = st_r;
        end else if (cls1 == CC_SINK && cls2 == CC_SINK) begin
          st_nxt = ST_SRC_DEBUG;
        end else if (cls1 == CC_CABLE && cls2 == CC_CABLE) begin
          st_nxt = ST_SRC_AUDIO;
        end else if (cls1 == CC_SINK || cls2 == CC_SINK) begin
          st_nxt = ST_SRC_ATT;
        end
      end
      ST_SRC_ATT: begin // only the sink pin counts for detach
        if ((orient_r ? cls2 : cls1) != CC_SINK) begin
          st_nxt = ST_SRC_WAIT;
        end
      end
      ST_SRC_DEBUG: begin
        if (!(cls1 == CC_SINK && cls2 == CC_SINK)) begin
          st_nxt = ST_SRC_WAIT;
        end
      end
      ST_SRC_AUDIO: begin
        if (!(cls1 == CC_CABLE && cls2 == CC_CABLE)) begin
          st_nxt = ST_SRC_WAIT;
        end
      end
      ST_SNK_WAIT: begin // orientation waits for vbus
        if (vbus_present && !f_src && !present_src_r) begin
          st_nxt = ST_SNK_ATT;
        end
      end
      ST_SNK_ATT: begin
        if (!vbus_present) begin
          st_nxt = ST_SNK_WAIT;
        end
      end
      default: st_nxt = ST_SRC_WAIT;
    endcase
    if (!en) begin
      st_nxt = (ctrl_r[CTRL_ROLE_LSB +: 2] == ROLE_SNK) ? ST_SNK_WAIT : ST_SRC_WAIT;
    end else if (ctrl_r[CTRL_ROLE_LSB +: 2] == ROLE_SNK && present_src_r) begin
      st_nxt = ST_SNK_WAIT; // fixed sink role never presents pull-ups
    end else if (ctrl_r[CTRL_ROLE_LSB +: 2] == ROLE_SRC && !present_src_r) begin
      st_nxt = ST_SRC_WAIT; // fixed source role never presents pull-downs
    end
  end

  // state, orientation latch and presentation
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= ST_SRC_WAIT;
      orient_r <= 1'b0;
      present_src_r <= 1'b1;
      tog_cnt_r <= '0;
    end else begin
      st_r <= st_nxt;
      present_src_r <= (st_nxt == ST_SRC_WAIT || st_nxt == ST_SRC_ATT ||
                        st_nxt == ST_SRC_DEBUG || st_nxt == ST_SRC_AUDIO);
      if (st_r == ST_SRC_WAIT && st_nxt == ST_SRC_ATT) begin
        orient_r <= (cls1 != CC_SINK);
      end else if (st_r == ST_SNK_WAIT && st_nxt == ST_SNK_ATT) begin
        orient_r <= f_hi2 && !f_hi1;
      end else if (st_nxt == ST_SRC_WAIT || st_nxt == ST_SNK_WAIT) begin
        orient_r <= 1'b0;
      end
      // dual role: swap presentation while nothing is found
      // hold still while a far termination is seen, else debounce never ends
      if (role_dual && en && st_r == st_nxt &&
          (st_r == ST_SRC_WAIT || st_r == ST_SNK_WAIT) &&
          !(present_src_r ? (cc1_term || cc2_term) : (cc1_hi || cc2_hi))) begin
        if (tog_cnt_r >= DRP_HALF_CYC[CNT_W-1:0]) begin
          tog_cnt_r <= '0;
          st_r <= (st_r == ST_SRC_WAIT) ? ST_SNK_WAIT : ST_SRC_WAIT;
          present_src_r <= (st_r != ST_SRC_WAIT);
        end else begin
          tog_cnt_r <= tog_cnt_r + 1'b1;
        end
      end else begin
        tog_cnt_r <= '0;
      end
    end
  end

  // pin and power outputs, one cycle behind the state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cc_pullup_en_r <= 1'b0;
      cc_pulldown_en_r <= 1'b0;
      vbus_en_r <= 1'b0;
      vconn_cc1_en_r <= 1'b0;
      vconn_cc2_en_r <= 1'b0;
      ss_sel_r <= 1'b0;
      debug_mode_r <= 1'b0;
      audio_mode_r <= 1'b0;
      attached_r <= 1'b0;
    end else begin
      cc_pullup_en_r <= present_src_r;
      cc_pulldown_en_r <= !present_src_r;
      // power only with a sink on the far end
      vbus_en_r <= (st_r == ST_SRC_ATT);
      // vconn on the pin away from the sink, optionally only if a load is there
      vconn_cc1_en_r <= (st_r == ST_SRC_ATT) && orient_r &&
                        (!ctrl_r[CTRL_VCONN_QUAL_BIT] || cls1 == CC_CABLE);
      vconn_cc2_en_r <= (st_r == ST_SRC_ATT) && !orient_r &&
                        (!ctrl_r[CTRL_VCONN_QUAL_BIT] || cls2 == CC_CABLE);
      ss_sel_r <= orient_r;
      debug_mode_r <= (st_r == ST_SRC_DEBUG);
      audio_mode_r <= (st_r == ST_SRC_AUDIO);
      attached_r <= (st_r == ST_SRC_ATT || st_r == ST_SNK_ATT);
    end
  end

  // ahb-lite slave: one wait state so a read always sees an earlier write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_r <= 1'b0;
      pend_wr_r <= 1'b0;
      pend_addr_r <= '0;
      hreadyout_r <= 1'b1;
    end else if (hsel && hready && htrans[1]) begin // address phase taken
      pend_r <= 1'b1;
      pend_wr_r <= hwrite;
      pend_addr_r <= haddr[7:0];
      hreadyout_r <= 1'b0;
    end else begin
      pend_r <= 1'b0;
      hreadyout_r <= 1'b1;
    end
  end

  // control register, and read data for the pending access
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= CTRL_RESET;
      hrdata_r <= '0;
    end else if (pend_r && pend_wr_r) begin
      if (pend_addr_r == REG_CTRL) begin
        ctrl_r <= hwdata[3:0];
      end
    end else if (pend_r) begin
      hrdata_r <= '0; // unmapped offsets read zero
      case (pend_addr_r)
        REG_CTRL: hrdata_r <= {28'h0000000, ctrl_r};
        REG_STATUS: begin
          hrdata_r[STAT_STATE_LSB +: 3] <= st_r;
          hrdata_r[STAT_CC1_LSB +: 2] <= cls1;
          hrdata_r[STAT_CC2_LSB +: 2] <= cls2;
          hrdata_r[STAT_SS_SEL_BIT] <= ss_sel_r;
          // lone cable load and where it sits
          hrdata_r[STAT_CABLE_BIT] <= (cls1 == CC_CABLE && cls2 == CC_OPEN) ||
                                      (cls2 == CC_CABLE && cls1 == CC_OPEN);
          hrdata_r[STAT_CABLE_POS_BIT] <= (cls1 == CC_CABLE);
          hrdata_r[STAT_VBUS_BIT] <= vbus_en_r;
          hrdata_r[STAT_VCONN_LSB +: 2] <= {vconn_cc2_en_r, vconn_cc1_en_r};
        end
        REG_STAGE: hrdata_r <= {30'h00000000, stage_r};
        default: hrdata_r <= '0;
      endcase
    end
  end

  // setup stage: only the next stage is accepted, detach goes back to detect
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage_r <= STAGE_DETECT;
    end else if (!attached_r) begin
      stage_r <= STAGE_DETECT;
    end else if (pend_r && pend_wr_r && pend_addr_r == REG_STAGE &&
                 stage_r != STAGE_ENUM && hwdata[1:0] == stage_r + 2'h1) begin
      stage_r <= hwdata[1:0];
    end
  end

  assign hreadyout = hreadyout_r;
  assign hrdata = hrdata_r;
  assign hresp = 1'b0;
  assign cc_pullup_en = cc_pullup_en_r;
  assign cc_pulldown_en = cc_pulldown_en_r;
  assign vbus_en = vbus_en_r;
  assign vconn_cc1_en = vconn_cc1_en_r;
  assign vconn_cc2_en = vconn_cc2_en_r;
  assign ss_sel = ss_sel_r;
  assign debug_mode = debug_mode_r;
  assign audio_mode = audio_mode_r;
  assign attached = attached_r;

  // power only follows a sink attach
  a_vbus_cause: assert property (vbus_en_r |-> $past(st_r) == ST_SRC_ATT)
    else $error("vbus on without sink attach");
  a_power_off_idle: assert property ($past(st_r) == ST_SRC_WAIT |->
      !vbus_en_r && !vconn_cc1_en_r && !vconn_cc2_en_r)
    else $error("power on while unattached");
  a_vconn_side: assert property (vconn_cc1_en_r |-> $past(orient_r) && !vconn_cc2_en_r)
    else $error("vconn on sink pin");
  a_orient_hold: assert property ((st_r == ST_SRC_ATT) && $past(st_r) == ST_SRC_ATT |->
      $stable(orient_r))
    else $error("orientation moved while attached");
  a_debug_entry: assert property (st_r == ST_SRC_WAIT && valid_src && en &&
      cls1 == CC_SINK && cls2 == CC_SINK |=> st_r == ST_SRC_DEBUG ##1 debug_mode_r)
    else $error("debug accessory not entered");
  a_audio_entry: assert property (st_r == ST_SRC_WAIT && valid_src && en &&
      cls1 == CC_CABLE && cls2 == CC_CABLE |=> st_r == ST_SRC_AUDIO ##1 audio_mode_r)
    else $error("audio accessory not entered");
  a_src_detach: assert property (st_r == ST_SRC_ATT && (orient_r ? cls2 : cls1) != CC_SINK
      |=> st_r == ST_SRC_WAIT ##1 !vbus_en_r)
    else $error("detach not taken");
  a_snk_wait_vbus: assert property (st_r == ST_SNK_WAIT && !vbus_present |=> st_r != ST_SNK_ATT)
    else $error("sink attached without vbus");
  a_snk_detach: assert property (st_r == ST_SNK_ATT && !vbus_present && en |=> st_r == ST_SNK_WAIT)
    else $error("vbus loss not seen as detach");
  a_stage_reset: assert property (!attached_r |=> stage_r == STAGE_DETECT)
    else $error("setup stage kept after detach");
  a_pull_pair: assert property (cc_pullup_en_r |-> !cc_pulldown_en_r && $past(present_src_r))
    else $error("pull terminations mixed");

endmodule // ccod_top

// [ccod_far_port.sv]
/*
  ccod_far_port: behavioural model of the port at the far end of the cable.
  assumes comparator outputs that follow the pin levels with no delay.
*/
`timescale 1ns/100ps
module ccod_far_port (
  input wire logic pullup_en, // our pull-ups on both pins
  input wire logic pulldown_en, // our pull-downs on both pins
  input wire ccod_pkg::ccod_term_t load1, // far load on cc1 while we source
  input wire ccod_pkg::ccod_term_t load2, // far load on cc2 while we source
  input wire logic far_src, // far side presents pull-ups
  input wire logic far_pos2, // far pull-up reaches our cc2
  input wire logic far_vbus, // far source applies vbus
  output logic cc1_term, // cc1 below unterminated level
  output logic cc1_ra, // cc1 below cable-load level
  output logic cc2_term, // cc2 below unterminated level
  output logic cc2_ra, // cc2 below cable-load level
  output logic cc1_hi, // cc1 above ground
  output logic cc2_hi, // cc2 above ground
  output logic vbus_present // vbus seen on our side
);
  import ccod_pkg::*;
  // source-role comparators from the far terminations
  always_comb begin
    if (pullup_en && !far_src) begin
      cc1_term = (load1 != CC_OPEN);
      cc1_ra = (load1 == CC_CABLE);
      cc2_term = (load2 != CC_OPEN);
      cc2_ra = (load2 == CC_CABLE);
    end else if (pullup_en) begin
      // two pull-ups: pins stay high, nothing seen
      cc1_term = 1'b0;
      cc1_ra = 1'b0;
      cc2_term = 1'b0;
      cc2_ra = 1'b0;
    end else begin
      // our own pull-downs drag both pins to ground
      cc1_term = 1'b1;
      cc1_ra = 1'b1;
      cc2_term = 1'b1;
      cc2_ra = 1'b1;
    end
  end
  // sink-role view: far pull-up lands on one pin only
  assign cc1_hi = pulldown_en && far_src && !far_pos2;
  assign cc2_hi = pulldown_en && far_src && far_pos2;
  assign vbus_present = far_src && far_vbus; // vbus only from a source
endmodule // ccod_far_port

// [test_cc_attach_orientation_detect.sv]
/*
  test_cc_attach_orientation_detect: self-checking bench for ccod_top.
  assumes ccod_far_port stands in for the remote port and one ahb master.
*/
`timescale 1ns/100ps
module test_cc_attach_orientation_detect;
  import ccod_pkg::*;
  logic hclk = 1'b0; // 20 MHz
  logic hresetn = 1'b0; // held low at start
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire logic hreadyout, hresp, cc_pullup_en, cc_pulldown_en, vbus_en, vconn_cc1_en;
  wire logic vconn_cc2_en, ss_sel, debug_mode, audio_mode, attached;
  wire logic [31:0] hrdata;
  wire logic cc1_term, cc1_ra, cc2_term, cc2_ra, cc1_hi, cc2_hi, vbus_present;
  ccod_term_t load1 = CC_OPEN; // far loads
  ccod_term_t load2 = CC_OPEN;
  logic far_src = 1'b0, far_pos2 = 1'b0, far_vbus = 1'b0, qual = 1'b0, saw_pd = 1'b0;
  int mismatches = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'h0000001A; // xorshift state
  logic rdy_n; // ready as sampled by the next edge
  logic [31:0] rd_n, rd_got;
  logic [31:0] rq_e[$], rq_m[$]; // pending read notes
  logic [8:0] pq_e[$], pq_m[$]; // pending pin notes
  event rd_ev, pin_ev;

  always #25 hclk = ~hclk;

  ccod_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cc1_term(cc1_term),
    .cc1_ra(cc1_ra), .cc2_term(cc2_term), .cc2_ra(cc2_ra), .cc1_hi(cc1_hi), .cc2_hi(cc2_hi),
    .vbus_present(vbus_present), .cc_pullup_en(cc_pullup_en),
    .cc_pulldown_en(cc_pulldown_en), .vbus_en(vbus_en), .vconn_cc1_en(vconn_cc1_en),
    .vconn_cc2_en(vconn_cc2_en), .ss_sel(ss_sel), .debug_mode(debug_mode),
    .audio_mode(audio_mode), .attached(attached));

  ccod_far_port far (.pullup_en(cc_pullup_en), .pulldown_en(cc_pulldown_en),
    .load1(load1), .load2(load2), .far_src(far_src), .far_pos2(far_pos2),
    .far_vbus(far_vbus), .cc1_term(cc1_term), .cc1_ra(cc1_ra), .cc2_term(cc2_term),
    .cc2_ra(cc2_ra), .cc1_hi(cc1_hi), .cc2_hi(cc2_hi), .vbus_present(vbus_present));

  // settled copies, so edge sampling never races the design
  always @(negedge hclk) begin
    rdy_n = hreadyout;
    rd_n = hrdata;
  end
  // remembers any pull-down presentation since last cleared
  always @(posedge hclk) begin
    if (cc_pulldown_en === 1'b1) saw_pd <= 1'b1;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task cmp_word(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    total_checks++;
    if (((got ^ exp) & m) !== 32'h0) begin
      mismatches++;
      $display("BAD %0t read got %h want %h", $time, got, exp);
    end
  endtask

  task cmp_pins(input logic [8:0] got, input logic [8:0] exp, input logic [8:0] m);
    total_checks++;
    if (((got ^ exp) & m) !== 9'h0) begin
      mismatches++;
      $display("BAD %0t pins got %h want %h", $time, got, exp);
    end
  endtask

  // monitor: oldest note against each result as it appears
  always @(rd_ev) cmp_word(rd_got, rq_e.pop_front(), rq_m.pop_front());
  always @(pin_ev) cmp_pins({saw_pd, cc_pullup_en, vbus_en, vconn_cc2_en, vconn_cc1_en,
    ss_sel, debug_mode, audio_mode, attached}, pq_e.pop_front(), pq_m.pop_front());

  // one single ahb transfer; entered just after a rising edge
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    hsel <= 1'b1;
    do begin @(posedge hclk); n++; end while (rdy_n !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do begin @(posedge hclk); n++; end while (rdy_n !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      $display("BAD %0t bus wait ran out", $time);
      give_verdict;
    end
    if (!wr) begin
      rd_got = rd_n;
      -> rd_ev;
    end
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    rq_e.push_back(e);
    rq_m.push_back(m);
    ahb(1'b0, a, 32'h0);
  endtask

  task snap(input logic [8:0] e, input logic [8:0] m);
    @(negedge hclk);
    pq_e.push_back(e);
    pq_m.push_back(m);
    -> pin_ev;
    @(posedge hclk);
  endtask

  // bounded wait for the attached level
  task wait_att;
    int n;
    for (n = 0; n < 10000 && attached !== 1'b1; n++) @(posedge hclk);
    if (n >= 10000) begin
      mismatches++;
      $display("BAD %0t attach never came", $time);
      give_verdict;
    end
  endtask

  // source role: present a load pair, expect pins and status
  task automatic src_case(input ccod_term_t a, input ccod_term_t b);
    logic s1, s2, att, acc, ss, lone, v1, v2;
    s1 = (a == CC_SINK);
    s2 = (b == CC_SINK);
    att = s1 ^ s2;
    acc = (s1 & s2) | (a == CC_CABLE && b == CC_CABLE);
    ss = att & s2;
    lone = (a != b) && !s1 && !s2;
    v1 = att & s2 & (!qual | (a == CC_CABLE));
    v2 = att & s1 & (!qual | (b == CC_CABLE));
    load1 <= a;
    load2 <= b;
    repeat (2300) @(posedge hclk);
    snap({2'b01, att, v2, v1, ss, s1 & s2, acc & !s1, att}, {2'b01, ~{4{acc}}, 3'h7});
    rd(REG_STATUS, {19'h0, v2, v1, att, (a == CC_CABLE), lone, ss, b, a, 1'b0,
      acc, att | (acc & !s1)}, {19'h0, ~{3{acc}}, ~att, 9'h1FF});
  endtask

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(REG_CTRL, 32'h1, 32'hFFFFFFFF);
    seed = xs(seed);
    ahb(1'b1, 8'h0C, seed);
    rd(8'h0C, 32'h0, 32'hFFFFFFFF);
    ahb(1'b1, REG_STATUS, seed);
    rd(REG_STATUS, 32'h0, 32'hFFFFFFFF);
    $display("test registers done");
    for (int k = 1; k < 9; k++) begin
      src_case(ccod_term_t'(k / 3), ccod_term_t'(k % 3));
      src_case(CC_OPEN, CC_OPEN);
    end
    $display("test patterns done");
    src_case(CC_OPEN, CC_SINK);
    for (int k = 0; k < 3; k++) begin
      ahb(1'b1, REG_STAGE, 32'(k + 2));
      rd(REG_STAGE, 32'(k), 32'h3);
      ahb(1'b1, REG_STAGE, 32'(k + 1));
      rd(REG_STAGE, 32'(k + 1), 32'h3);
    end
    src_case(CC_OPEN, CC_OPEN);
    rd(REG_STAGE, 32'h0, 32'h3);
    $display("test stages done");
    qual = 1'b1;
    ahb(1'b1, REG_CTRL, 32'h9);
    src_case(CC_SINK, CC_OPEN);
    src_case(CC_SINK, CC_CABLE);
    src_case(CC_OPEN, CC_OPEN);
    qual = 1'b0;
    ahb(1'b1, REG_CTRL, 32'h1);
    $display("test vconn gate done");
    seed = xs(seed);
    load1 <= CC_SINK;
    repeat (500 + int'(seed[9:0])) @(posedge hclk);
    load1 <= CC_OPEN;
    @(posedge hclk);
    load1 <= CC_SINK;
    repeat (1900) @(posedge hclk);
    snap(9'h000, 9'h001);
    repeat (400) @(posedge hclk);
    snap(9'h001, 9'h001);
    src_case(CC_OPEN, CC_OPEN);
    $display("test debounce done");
    far_src <= 1'b1;
    load1 <= CC_SINK;
    repeat (2300) @(posedge hclk);
    snap(9'h080, 9'h0FF);
    far_src <= 1'b0;
    load1 <= CC_OPEN;
    $display("test two sources done");
    ahb(1'b1, REG_CTRL, 32'h3);
    repeat (2300) @(posedge hclk);
    snap(9'h000, 9'h0C1);
    far_src <= 1'b1;
    repeat (2300) @(posedge hclk);
    snap(9'h000, 9'h049);
    far_vbus <= 1'b1;
    wait_att;
    snap(9'h001, 9'h049);
    far_vbus <= 1'b0;
    repeat (3) @(posedge hclk);
    snap(9'h000, 9'h049);
    far_pos2 <= 1'b1;
    repeat (2300) @(posedge hclk);
    far_vbus <= 1'b1;
    wait_att;
    snap(9'h009, 9'h049);
    far_vbus <= 1'b0;
    far_src <= 1'b0;
    repeat (3) @(posedge hclk);
    snap(9'h000, 9'h049);
    $display("test sink role done");
    ahb(1'b1, REG_CTRL, 32'h5);
    @(negedge hclk);
    saw_pd = 1'b0;
    @(posedge hclk);
    load1 <= CC_SINK;
    wait_att;
    repeat (3) @(posedge hclk);
    snap(9'h1E1, 9'h1FF);
    $display("test dual role done");
    give_verdict;
  end
endmodule // test_cc_attach_orientation_detect
